// ### rtl/lcgs_gate_or.sv
// module: one gate combining its enabled true and inverted source terms
`timescale 1ns/1ps
module lcgs_gate_or #(
   parameter int NUM_SRC = 4
) (
   input  wire logic [NUM_SRC-1:0]   src_in,
   input  wire logic [2*NUM_SRC-1:0] en_in,
   output logic                      gate_out
);
   // ==========================================================================
   // term selection
   logic [2*NUM_SRC-1:0] terms;

   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i++) begin : g_src
         // pair layout: odd bit true enable, even bit inverted enable
         assign terms[2*i+lcgs_pkg::TRUE_OFS] = en_in[2*i+lcgs_pkg::TRUE_OFS] & src_in[i];
         assign terms[2*i+lcgs_pkg::INV_OFS]  = en_in[2*i+lcgs_pkg::INV_OFS] & ~src_in[i];
      end
   endgenerate

   // no enabled term gives constant low
   assign gate_out = |terms;
endmodule : lcgs_gate_or

// ### rtl/lcgs_pkg.sv
// package: register map and field layout of the gate input select low block
package lcgs_pkg;
   // ==========================================================================
   // register map
   localparam logic [11:0] GATE_SEL_LOW_OFS   = 12'h000;
   localparam logic [11:0] GATE_OUT_STAT_OFS  = 12'h004;
   localparam logic [15:0] GATE_SEL_LOW_RST   = 16'h0000;
   localparam int          SEL_WIDTH          = 16;
   localparam int          NUM_SRC            = 4;
   // ==========================================================================
   // field positions: each gate owns one byte, two bits per source
   localparam int          GATE1_BASE         = 0;
   localparam int          GATE2_BASE         = 8;
   localparam int          INV_OFS            = 0;
   localparam int          TRUE_OFS           = 1;
   localparam int          BITS_PER_SRC       = 2;
   // ==========================================================================
   // status register layout
   localparam int          STAT_GATE1_BIT     = 0;
   localparam int          STAT_GATE2_BIT     = 1;
endpackage : lcgs_pkg

// ### rtl/lcgs_top.sv
// module: gate 1 and 2 input enable matrix with apb register access
//
// Contract
// - bits 15,13,11,9 pass true source 4,3,2,1 into gate 2 when set
// - bits 14,12,10,8 pass inverted source 4,3,2,1 into gate 2 when set
// - bits 7,5,3,1 pass true source 4,3,2,1 into gate 1 when set
// - bits 6,4,2,0 pass inverted source 4,3,2,1 into gate 1 when set
// - all sixteen bits read/write and clear to zero at reset
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module lcgs_top #(
   parameter int NUM_SRC = lcgs_pkg::NUM_SRC
) (
   input  wire logic               core_clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [11:0]        paddr_in,
   input  wire logic [31:0]        pwdata_in,
   input  wire logic [3:0]         pstrb_in,
   output logic      [31:0]        prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   input  wire logic [NUM_SRC-1:0] src_in,
   output logic                    gate1_out,
   output logic                    gate2_out
);
   // ==========================================================================
   // state
   typedef struct packed {
      logic [15:0] sel;
      logic [31:0] rdata;
      logic        err;
      logic        g1;
      logic        g2;
   } lcgs_state_s;

   lcgs_state_s state_reg;
   lcgs_state_s state_next;
   logic        g1_comb;
   logic        g2_comb;
   logic        access;
   logic        model_g1;
   logic        model_g2;

   // reset image of the whole state: select clear, so no source reaches a gate
   localparam lcgs_state_s STATE_RST = '{
      sel:   lcgs_pkg::GATE_SEL_LOW_RST,
      rdata: 32'h0000_0000,
      err:   1'b0,
      g1:    1'b0,
      g2:    1'b0
   };

   function automatic logic addr_known(input logic [11:0] a);
      return (a == lcgs_pkg::GATE_SEL_LOW_OFS) || (a == lcgs_pkg::GATE_OUT_STAT_OFS);
   endfunction : addr_known

   // ==========================================================================
   // gates
   lcgs_gate_or #(.NUM_SRC(NUM_SRC)) u_gate1 (
      .src_in   (src_in),
      .en_in    (state_reg.sel[lcgs_pkg::GATE1_BASE +: 2*NUM_SRC]),
      .gate_out (g1_comb)
   );
   lcgs_gate_or #(.NUM_SRC(NUM_SRC)) u_gate2 (
      .src_in   (src_in),
      .en_in    (state_reg.sel[lcgs_pkg::GATE2_BASE +: 2*NUM_SRC]),
      .gate_out (g2_comb)
   );

   // ==========================================================================
   // apb slave: zero wait, answer in the access cycle
   assign access      = psel_in & penable_in;
   assign pready_out  = 1'b1;
   assign prdata_out  = state_reg.rdata;
   assign pslverr_out = state_reg.err;
   assign gate1_out   = state_reg.g1;
   assign gate2_out   = state_reg.g2;

   always_comb begin
      state_next    = state_reg;
      state_next.g1 = g1_comb;
      state_next.g2 = g2_comb;
      // read data prepared in setup so it is registered at the access edge
      if (psel_in && !penable_in && !pwrite_in) begin
         state_next.rdata = 32'h0000_0000;
         state_next.err   = ~addr_known(paddr_in);
         if (paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS) begin
            state_next.rdata[15:0] = state_reg.sel;
         end else if (paddr_in == lcgs_pkg::GATE_OUT_STAT_OFS) begin
            state_next.rdata[lcgs_pkg::STAT_GATE1_BIT] = state_reg.g1;
            state_next.rdata[lcgs_pkg::STAT_GATE2_BIT] = state_reg.g2;
         end
      end else if (psel_in && !penable_in) begin
         state_next.err = ~addr_known(paddr_in);
      end
      if (access && pwrite_in && paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS) begin
         if (pstrb_in[0]) begin
            state_next.sel[7:0] = pwdata_in[7:0];
         end
         if (pstrb_in[1]) begin
            state_next.sel[15:8] = pwdata_in[15:8];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================================
   // reference model for the checks
   // written apart from the gate submodule so a slip in either one shows up
   function automatic logic gate_model(
      input logic [2*lcgs_pkg::NUM_SRC-1:0] en,
      input logic [lcgs_pkg::NUM_SRC-1:0]   src
   );
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < lcgs_pkg::NUM_SRC; k++) begin
         hit = hit | (en[lcgs_pkg::BITS_PER_SRC*k+lcgs_pkg::TRUE_OFS] & src[k]);
         hit = hit | (en[lcgs_pkg::BITS_PER_SRC*k+lcgs_pkg::INV_OFS] & ~src[k]);
      end
      return hit;
   endfunction : gate_model

   assign model_g1 = gate_model(state_reg.sel[lcgs_pkg::GATE1_BASE +: 2*NUM_SRC], src_in);
   assign model_g2 = gate_model(state_reg.sel[lcgs_pkg::GATE2_BASE +: 2*NUM_SRC], src_in);

   // ==========================================================================
   // assertions: register access
   a_reset_clear: assert property (
      @(posedge core_clk_in)
      $rose(rst_n_in) |-> state_reg.sel == lcgs_pkg::GATE_SEL_LOW_RST
   ) else $error("select not clear after reset");

   a_write_takes: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      access && pwrite_in && paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS && pstrb_in == 4'hF
      |=> state_reg.sel == $past(pwdata_in[15:0])
   ) else $error("write not stored");

   a_read_back: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      access && !pwrite_in && paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS
      |=> prdata_out == {16'h0000, $past(state_reg.sel)}
   ) else $error("read data wrong");

   a_read_upper_zero: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      access && !pwrite_in
      |-> prdata_out[31:16] == 16'h0000
   ) else $error("upper read half not zero");

   a_low_lane_keep: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      access && pwrite_in && paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS && !pstrb_in[0]
      |=> state_reg.sel[7:0] == $past(state_reg.sel[7:0])
   ) else $error("gate1 byte changed without strobe");

   a_high_lane_keep: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      access && pwrite_in && paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS && !pstrb_in[1]
      |=> state_reg.sel[15:8] == $past(state_reg.sel[15:8])
   ) else $error("gate2 byte changed without strobe");

   a_other_write_keep: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      access && pwrite_in && paddr_in != lcgs_pkg::GATE_SEL_LOW_OFS
      |=> $stable(state_reg.sel)
   ) else $error("select changed by another address");

   // ==========================================================================
   // assertions: gate terms
   a_gate2_true: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg.sel[15] && src_in[3]
      |=> gate2_out
   ) else $error("gate2 true src4 missing");

   a_gate2_inv: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg.sel[8] && !src_in[0]
      |=> gate2_out
   ) else $error("gate2 inv src1 missing");

   a_gate1_true: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg.sel[1] && src_in[0]
      |=> gate1_out
   ) else $error("gate1 true src1 missing");

   a_gate1_inv: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg.sel[6] && !src_in[3]
      |=> gate1_out
   ) else $error("gate1 inv src4 missing");

   a_gate_idle_low: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg.sel[7:0] == 8'h00
      |=> !gate1_out
   ) else $error("gate1 high with no term");

   a_gate2_idle_low: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      state_reg.sel[15:8] == 8'h00
      |=> !gate2_out
   ) else $error("gate2 high with no term");

   // full truth table, so a stray extra term is caught too
   a_gate1_model: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      1'b1
      |=> gate1_out == $past(model_g1)
   ) else $error("gate1 differs from model");

   a_gate2_model: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      1'b1
      |=> gate2_out == $past(model_g2)
   ) else $error("gate2 differs from model");

   // ==========================================================================
   // covers
   c_write_sel: cover property (
      @(posedge core_clk_in) access && pwrite_in && paddr_in == lcgs_pkg::GATE_SEL_LOW_OFS
   );
   c_read_stat: cover property (
      @(posedge core_clk_in) access && !pwrite_in && paddr_in == lcgs_pkg::GATE_OUT_STAT_OFS
   );
   c_bad_addr: cover property (
      @(posedge core_clk_in) access && pslverr_out
   );
   c_both_high: cover property (
      @(posedge core_clk_in) gate1_out && gate2_out
   );
   c_part_strobe: cover property (
      @(posedge core_clk_in) access && pwrite_in && pstrb_in[1:0] == 2'b01
   );
endmodule : lcgs_top

// ### testbench/testbench.sv
// testbench: apb access and gate enable matrix checks for lcgs_top
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [3:0]  pstrb = 4'hF, src = 4'h0, sb;
   logic        pready, pslverr, g1, g2, err;
   logic [15:0] sel, wv;
   int          miscompares = 0, n_checks = 0, seed = 32'hc213;
   lcgs_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .src_in(src),
      .gate1_out(g1), .gate2_out(g2));
   always #20 clk = ~clk;
   // ==========================================================================
   // shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task print_verdict();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // master holds the request until pready is sampled high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   function automatic logic gexp(input logic [15:0] s, input logic [3:0] x, input int g);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 4; i++) r |= (s[g*8+2*i+1] & x[i]) | (s[g*8+2*i] & ~x[i]);
      return r;
   endfunction : gexp
   // one edge launches src, the next registers the gates, one more as margin
   task gates(input logic [3:0] x);
      @(posedge clk); src <= x; @(posedge clk); @(posedge clk); #1;
      chk({31'h0, g1}, {31'h0, gexp(sel, x, 0)});
      chk({31'h0, g2}, {31'h0, gexp(sel, x, 1)});
   endtask : gates
   // ==========================================================================
   // watchdog: whole run is well under 20000 cycles
   initial begin #(40 * 20000); miscompares++; print_verdict(); end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      sel = 16'h0000;
      apb(1'b0, lcgs_pkg::GATE_SEL_LOW_OFS, 32'h0, 4'hF);
      chk(rd, 32'h0);
      gates(4'h0); gates(4'hF);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         sel = 16'h1 << i;
         apb(1'b1, lcgs_pkg::GATE_SEL_LOW_OFS, {16'hFFFF, sel}, 4'hF);
         apb(1'b0, lcgs_pkg::GATE_SEL_LOW_OFS, 32'h0, 4'hF);
         chk(rd, {16'h0, sel});
         for (int x = 0; x < 16; x++) gates(x[3:0]);
      end
      $display("test bit walk done");
      for (int k = 0; k < 60; k++) begin
         wv = 16'($random(seed));
         sb = 4'($random(seed));
         if (k < 4) sb = 4'hF;
         sel = {sb[1] ? wv[15:8] : sel[15:8], sb[0] ? wv[7:0] : sel[7:0]};
         apb(1'b1, lcgs_pkg::GATE_SEL_LOW_OFS, {16'($random(seed)), wv}, sb);
         apb(1'b0, lcgs_pkg::GATE_SEL_LOW_OFS, 32'h0, 4'hF);
         chk(rd, {16'h0, sel});
         gates(4'($random(seed)));
         apb(1'b0, lcgs_pkg::GATE_OUT_STAT_OFS, 32'h0, 4'hF);
         chk(rd, {30'h0, gexp(sel, src, 1), gexp(sel, src, 0)});
      end
      $display("test random done");
      // reset in mid-run must clear whatever the random phase left behind
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      sel = 16'h0000;
      apb(1'b0, lcgs_pkg::GATE_SEL_LOW_OFS, 32'h0, 4'hF);
      chk(rd, 32'h0);
      gates(4'h5); gates(4'hA);
      $display("test mid reset done");
      apb(1'b1, 12'h008, 32'hFFFF, 4'hF);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, lcgs_pkg::GATE_OUT_STAT_OFS, 32'hFFFF, 4'hF);
      apb(1'b0, 12'h008, 32'h0, 4'hF);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b0, lcgs_pkg::GATE_SEL_LOW_OFS, 32'h0, 4'hF);
      chk(rd, {16'h0, sel});
      $display("test unmapped done");
      print_verdict();
   end
endmodule : testbench
